//--- logic/sws_port_ctrl.sv
/*
 * Per-port bridge control field group and power management
 * capability header, with the routing, error, poison and hot reset
 * behaviour those fields steer.
 * Assumes configuration accesses, loader strobes and the upstream
 * port's hot reset level all arrive on sys_clk_i.
 */
// Operation
// R1 - Bit 16 enables poisoned packet detection on secondary; clear ignores them.
// R2 - Bit 17 gates forwarding of secondary error messages to primary.
// R3 - Bit 18 sends legacy-aliased window I/O in first 64KB upstream.
// R4 - Bit 19 forwards display memory A0000h to BFFFFh when set, else ignores.
// R5 - Display enable also forwards low-64KB I/O at 3B0-3BBh and 3C0-3DFh.
// R6 - Bit 20 picks 16-bit display I/O decode; clear picks 10-bit.
// R7 - Bit 22 hot-resets this port; downstream drives its port reset.
// R8 - Upstream port hot reset bit resets every downstream port.
// R9 - Legacy-bus-only bits 21, 23-27 and capability bit 19 read zero.
// R10 - Capability bits 7:0 return identifier 01h.
// R11 - Next pointer is 5Ch on upstream port, 4Ch downstream.
// R12 - Bits 18:16 read constant 011b for interface revision 1.2.
// R13 - Bit 21 reads 0 by default, replaceable by side-band loader.
// R14 - Auxiliary current bits 24:22 reset to 111b, loadable, read-only.
// R15 - Bits 25 and 26 default 1 for D1/D2 support, loadable.
// R16 - Bits 31:27 default 11111b for event support, loadable.
// R17 - Loader may override defaults in bits 31:21; capability bit 20 reserved.
// R18 - Writes to read-only or reserved fields change nothing; reserved read zero.
`timescale 1ns/1ps
module sws_port_ctrl
    import sws_pkg::*;
#(
    parameter bit IS_UPSTREAM = 1'b0
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Configuration access port
    input wire logic cfg_wr_i,
    input wire logic cfg_rd_i,
    input wire logic [7:0] cfg_addr_i,
    input wire logic [3:0] cfg_be_i,
    input wire logic [31:0] cfg_wdata_i,
    output logic [31:0] cfg_rdata_o,
    output logic cfg_rvalid_o,
    // Side-band default loader
    input wire logic ld_valid_i,
    input wire logic [SWS_LD_W-1:0] ld_data_i,
    // Poisoned packets seen on the secondary side
    input wire logic poison_valid_i,
    output logic poison_report_o,
    // Error messages arriving from the secondary side
    input wire logic err_msg_valid_i,
    input wire logic [1:0] err_msg_type_i,
    output logic err_fwd_valid_o,
    output logic [1:0] err_fwd_type_o,
    // I/O routing request
    input wire logic io_req_valid_i,
    input wire logic [31:0] io_addr_i,
    input wire logic io_in_window_i,
    output logic io_route_valid_o,
    output logic io_to_downstream_o,
    output logic io_to_upstream_o,
    // Memory routing request for the display range
    input wire logic mem_req_valid_i,
    input wire logic [31:0] mem_addr_i,
    output logic mem_route_valid_o,
    output logic mem_vga_fwd_o,
    // Hot reset
    input wire logic up_hot_reset_i,
    output logic hot_reset_o,
    output logic dn_hot_reset_o,
    output logic port_rst_n_o
);
    // Writable bridge control bits, each stored in its own flop
    logic poison_en_q;
    logic err_fwd_en_q;
    logic legacy_io_window_enable_q;
    logic vga_en_q;
    logic vga16_q;
    logic hot_rst_q;

    logic [31:0] rdata_q;
    logic rvalid_q;
    logic poison_report_q;
    logic err_fwd_valid_q;
    logic [1:0] err_fwd_type_q;
    logic io_route_valid_q;
    logic io_to_downstream_q;
    logic io_to_upstream_q;
    logic mem_route_valid_q;
    logic mem_vga_fwd_q;
    logic hot_reset_q;
    logic dn_hot_reset_q;
    logic port_rst_n_q;

    logic [SWS_LD_W-1:0] cap_ld;
    logic vga_io_hit;
    logic legacy_alias;
    logic vga_mem_hit;
    logic bc_sel;
    logic cap_sel;
    logic bc_wr;
    logic [31:0] bc_word;
    logic [31:0] cap_word;
    logic [7:0] next_ptr;
    logic port_hot;

    // Loadable capability fields live in their own small holder
    sws_cap_fields u_cap (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .ld_valid_i(ld_valid_i),
        .ld_data_i(ld_data_i),
        .fields_o(cap_ld)
    );

    // Shared range decode, result registered below
    sws_legacy_decode u_dec (
        .io_addr_i(io_addr_i),
        .mem_addr_i(mem_addr_i),
        .vga16_i(vga16_q),
        .vga_io_hit_o(vga_io_hit),
        .legacy_alias_o(legacy_alias),
        .vga_mem_hit_o(vga_mem_hit)
    );

    // Address decode; other offsets fall through to a zero read
    assign bc_sel = (cfg_addr_i == SWS_OFF_BRIDGE_CTRL);
    assign cap_sel = (cfg_addr_i == SWS_OFF_PM_CAP);

    // Only lane 2 holds writable control bits; other lanes are ignored
    assign bc_wr = cfg_wr_i && bc_sel && cfg_be_i[SWS_BE_BC_LANE];

    // Pointer is fixed by which side of the switch this port sits on
    assign next_ptr = IS_UPSTREAM ? SWS_NEXT_PTR_UP : SWS_NEXT_PTR_DN; // see R11

    // Bridge control read image; hardwired legacy bits stay zero
    always_comb begin
        bc_word = 32'h0000_0000; // see R9 see R18
        bc_word[SWS_BC_POISON] = poison_en_q;
        bc_word[SWS_BC_ERR_FWD] = err_fwd_en_q;
        bc_word[SWS_BC_LEGACY_IO] = legacy_io_window_enable_q;
        bc_word[SWS_BC_VGA] = vga_en_q;
        bc_word[SWS_BC_VGA16] = vga16_q;
        bc_word[SWS_BC_HOT_RST] = hot_rst_q;
    end

    // Capability header read image
    always_comb begin
        // Bit order: 31:27 evt, 26 d2, 25 d1, 24:22 aux, 21 dsi, 20 reserved
        cap_word = {cap_ld[10:1], // see R14 see R15 see R16
                    cap_ld[0], // see R13
                    SWS_CAP_RSVD, // see R17
                    SWS_EVT_CLK, // see R9
                    SWS_PM_REV, // see R12
                    next_ptr,
                    SWS_CAP_ID}; // see R10
    end

    // Bridge control write; read-only and reserved bits are dropped
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            poison_en_q <= 1'b0;
            err_fwd_en_q <= 1'b0;
            legacy_io_window_enable_q <= 1'b0;
            vga_en_q <= 1'b0;
            vga16_q <= 1'b0;
            hot_rst_q <= 1'b0;
        end else if (bc_wr) begin
            poison_en_q <= cfg_wdata_i[SWS_BC_POISON]; // see R1
            err_fwd_en_q <= cfg_wdata_i[SWS_BC_ERR_FWD]; // see R2
            legacy_io_window_enable_q <= cfg_wdata_i[SWS_BC_LEGACY_IO]; // see R3
            vga_en_q <= cfg_wdata_i[SWS_BC_VGA]; // see R4
            vga16_q <= cfg_wdata_i[SWS_BC_VGA16]; // see R6
            hot_rst_q <= cfg_wdata_i[SWS_BC_HOT_RST]; // see R7
        end
    end

    // Read data; capability writes are simply not decoded
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            rdata_q <= 32'h0000_0000;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= cfg_rd_i;
            if (cfg_rd_i) begin
                if (bc_sel) begin
                    rdata_q <= bc_word;
                end else if (cap_sel) begin
                    rdata_q <= cap_word; // see R18
                end else begin
                    rdata_q <= 32'h0000_0000;
                end
            end
        end
    end

    // Poisoned packets are reported only while detection is enabled
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            poison_report_q <= 1'b0;
        end else begin
            poison_report_q <= poison_valid_i && poison_en_q; // see R1
        end
    end

    // Error message forwarding; a blocked message is dropped, not held
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            err_fwd_valid_q <= 1'b0;
            err_fwd_type_q <= 2'h0;
        end else begin
            err_fwd_valid_q <= err_msg_valid_i && err_fwd_en_q; // see R2
            if (err_msg_valid_i) begin
                err_fwd_type_q <= err_msg_type_i;
            end
        end
    end

    // I/O routing. Display ranges win over the legacy alias test, so a
    // display register inside the window is still sent downstream.
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            io_route_valid_q <= 1'b0;
            io_to_downstream_q <= 1'b0;
            io_to_upstream_q <= 1'b0;
        end else begin
            io_route_valid_q <= io_req_valid_i;
            if (io_req_valid_i) begin
                if (vga_en_q && vga_io_hit) begin
                    io_to_downstream_q <= 1'b1; // see R5
                    io_to_upstream_q <= 1'b0;
                end else if (io_in_window_i && legacy_io_window_enable_q &&
                             legacy_alias) begin
                    io_to_downstream_q <= 1'b0; // see R3
                    io_to_upstream_q <= 1'b1;
                end else if (io_in_window_i) begin
                    io_to_downstream_q <= 1'b1;
                    io_to_upstream_q <= 1'b0;
                end else begin
                    io_to_downstream_q <= 1'b0;
                    io_to_upstream_q <= 1'b1;
                end
            end
        end
    end

    // Display memory forwarding
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            mem_route_valid_q <= 1'b0;
            mem_vga_fwd_q <= 1'b0;
        end else begin
            mem_route_valid_q <= mem_req_valid_i;
            if (mem_req_valid_i) begin
                mem_vga_fwd_q <= vga_en_q && vga_mem_hit; // see R4
            end
        end
    end

    // Downstream ports also obey the upstream port's reset request
    assign port_hot = hot_rst_q || (!IS_UPSTREAM && up_hot_reset_i);

    // Hot reset levels follow the control bit for as long as it is set
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            hot_reset_q <= 1'b0;
            dn_hot_reset_q <= 1'b0;
            port_rst_n_q <= 1'b1;
        end else begin
            hot_reset_q <= port_hot; // see R7
            dn_hot_reset_q <= IS_UPSTREAM && hot_rst_q; // see R8
            port_rst_n_q <= IS_UPSTREAM || !port_hot; // see R7 see R8
        end
    end

    assign cfg_rdata_o = rdata_q;
    assign cfg_rvalid_o = rvalid_q;
    assign poison_report_o = poison_report_q;
    assign err_fwd_valid_o = err_fwd_valid_q;
    assign err_fwd_type_o = err_fwd_type_q;
    assign io_route_valid_o = io_route_valid_q;
    assign io_to_downstream_o = io_to_downstream_q;
    assign io_to_upstream_o = io_to_upstream_q;
    assign mem_route_valid_o = mem_route_valid_q;
    assign mem_vga_fwd_o = mem_vga_fwd_q;
    assign hot_reset_o = hot_reset_q;
    assign dn_hot_reset_o = dn_hot_reset_q;
    assign port_rst_n_o = port_rst_n_q;
endmodule

//--- shared/sws_pkg.sv
/*
 * Constants for the per-port bridge control and power management
 * capability header block: offsets, field positions, reset values
 * and legacy decode limits.
 * Assumes byte addresses on the configuration port, dword aligned.
 */
package sws_pkg;
    // Register byte offsets
    localparam logic [7:0] SWS_OFF_BRIDGE_CTRL = 8'h3c;
    localparam logic [7:0] SWS_OFF_PM_CAP = 8'h40;

    // Bridge control bit positions within the dword
    localparam int SWS_BC_POISON = 16;
    localparam int SWS_BC_ERR_FWD = 17;
    localparam int SWS_BC_LEGACY_IO = 18;
    localparam int SWS_BC_VGA = 19;
    localparam int SWS_BC_VGA16 = 20;
    localparam int SWS_BC_HOT_RST = 22;
    localparam int SWS_BC_LO = 16;
    localparam int SWS_BC_HI = 22;
    localparam int SWS_BC_W = 7;

    // Byte lane that carries the writable control bits
    localparam int SWS_BE_BC_LANE = 2;

    // Capability header fixed fields
    localparam logic [7:0] SWS_CAP_ID = 8'h01;
    localparam logic [7:0] SWS_NEXT_PTR_UP = 8'h5c;
    localparam logic [7:0] SWS_NEXT_PTR_DN = 8'h4c;
    localparam logic [2:0] SWS_PM_REV = 3'h3;
    localparam logic [0:0] SWS_EVT_CLK = 1'h0;
    localparam logic [0:0] SWS_CAP_RSVD = 1'h0;

    // Loadable capability defaults, packed as {evt_support, d2, d1, aux, dsi}
    localparam int SWS_LD_W = 11;
    localparam logic [0:0] SWS_DSI_RST = 1'h0;
    localparam logic [2:0] SWS_AUX_RST = 3'h7;
    localparam logic [0:0] SWS_D1_RST = 1'h1;
    localparam logic [0:0] SWS_D2_RST = 1'h1;
    localparam logic [4:0] SWS_EVT_SUP_RST = 5'h1f;

    // Legacy display memory range
    localparam logic [31:0] SWS_VGA_MEM_LO = 32'h000a_0000;
    localparam logic [31:0] SWS_VGA_MEM_HI = 32'h000b_ffff;
    // Legacy display I/O ranges on the low ten address bits
    localparam logic [9:0] SWS_VGA_IO_A_LO = 10'h3b0;
    localparam logic [9:0] SWS_VGA_IO_A_HI = 10'h3bb;
    localparam logic [9:0] SWS_VGA_IO_B_LO = 10'h3c0;
    localparam logic [9:0] SWS_VGA_IO_B_HI = 10'h3df;

    // Error message kinds
    typedef enum logic [1:0] {
        SWS_ERR_COR,
        SWS_ERR_NONFATAL,
        SWS_ERR_FATAL
    } sws_err_t;
endpackage

//--- logic/sws_cap_fields.sv
/*
 * Loadable read-only defaults of the power management capability.
 * Assumes the management bus or autoload engine presents a packed
 * value with a one-cycle strobe on the same clock.
 */
`timescale 1ns/1ps
module sws_cap_fields
    import sws_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic ld_valid_i,
    input wire logic [SWS_LD_W-1:0] ld_data_i,
    output logic [SWS_LD_W-1:0] fields_o
);
    logic [SWS_LD_W-1:0] fields_q;

    // Reset defaults, replaced only by the side-band loader (see R13)
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            fields_q <= {SWS_EVT_SUP_RST, SWS_D2_RST, SWS_D1_RST,
                         SWS_AUX_RST, SWS_DSI_RST}; // see R14 see R15 see R16
        end else if (ld_valid_i) begin
            fields_q <= ld_data_i; // see R17
        end
    end

    assign fields_o = fields_q;
endmodule

//--- logic/sws_legacy_decode.sv
/*
 * Combinational legacy decode: display memory and I/O ranges, and
 * the legacy I/O alias test. Caller registers the results.
 * Assumes addresses are stable while the request is valid.
 */
`timescale 1ns/1ps
module sws_legacy_decode
    import sws_pkg::*;
(
    input wire logic [31:0] io_addr_i,
    input wire logic [31:0] mem_addr_i,
    input wire logic vga16_i,
    output logic vga_io_hit_o,
    output logic legacy_alias_o,
    output logic vga_mem_hit_o
);
    logic first_64k;
    logic low_hit;

    // First 64KB; 16-bit decode also demands no aliases above bit 9
    always_comb begin
        first_64k = (io_addr_i[31:16] == 16'h0000);
        low_hit = ((io_addr_i[9:0] >= SWS_VGA_IO_A_LO) &&
                   (io_addr_i[9:0] <= SWS_VGA_IO_A_HI)) ||
                  ((io_addr_i[9:0] >= SWS_VGA_IO_B_LO) &&
                   (io_addr_i[9:0] <= SWS_VGA_IO_B_HI)); // see R5
        vga_io_hit_o = first_64k && low_hit &&
                       (!vga16_i || (io_addr_i[15:10] == 6'h00)); // see R6
        // Top 768 bytes of each 1KB block means bits 9:8 not both zero
        legacy_alias_o = first_64k && (io_addr_i[9:8] != 2'h0); // see R3
        vga_mem_hit_o = (mem_addr_i >= SWS_VGA_MEM_LO) &&
                        (mem_addr_i <= SWS_VGA_MEM_HI); // see R4
    end
endmodule

//--- verif/sws_port_ctrl_assertions.sv
/* Port checker for sws_port_ctrl: read timing, field values, fault
   gating, display memory routing and hot reset lag.
   Assumes it is bound to each sws_port_ctrl; one clock domain. */
`timescale 1ns/1ps
module sws_port_ctrl_assertions
    import sws_pkg::*;
#(
    parameter bit IS_UPSTREAM = 1'b0
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic cfg_wr_i,
    input wire logic cfg_rd_i,
    input wire logic [7:0] cfg_addr_i,
    input wire logic [3:0] cfg_be_i,
    input wire logic [31:0] cfg_wdata_i,
    input wire logic [31:0] cfg_rdata_o,
    input wire logic cfg_rvalid_o,
    input wire logic poison_valid_i,
    input wire logic poison_report_o,
    input wire logic err_msg_valid_i,
    input wire logic [1:0] err_msg_type_i,
    input wire logic err_fwd_valid_o,
    input wire logic [1:0] err_fwd_type_o,
    input wire logic mem_req_valid_i,
    input wire logic [31:0] mem_addr_i,
    input wire logic mem_vga_fwd_o,
    input wire logic up_hot_reset_i,
    input wire logic hot_reset_o,
    input wire logic port_rst_n_o
);
    logic [6:0] ctl_q;
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // Shadow of the control bits; bit 21 masked since it is hardwired
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            ctl_q <= 7'h00;
        end else if (cfg_wr_i && cfg_addr_i == SWS_OFF_BRIDGE_CTRL && cfg_be_i[2]) begin
            ctl_q <= cfg_wdata_i[22:16] & 7'h5f;
        end
    end

    rd_answer_a: assert property (cfg_rvalid_o == $past(cfg_rd_i))
        else $error("read answer timing wrong");
    ctl_read_a: assert property (cfg_rvalid_o && $past(cfg_addr_i) == 8'h3c
        |-> cfg_rdata_o == {9'h000, $past(ctl_q), 16'h0000}) else $error("control read wrong");
    cap_fixed_a: assert property (cfg_rvalid_o && $past(cfg_addr_i) == 8'h40
        |-> cfg_rdata_o[20:0] == {5'h03, (IS_UPSTREAM ? 8'h5c : 8'h4c), 8'h01})
        else $error("capability fixed fields wrong");
    unmapped_zero_a: assert property (cfg_rvalid_o && $past(cfg_addr_i) != 8'h3c
        && $past(cfg_addr_i) != 8'h40 |-> cfg_rdata_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    poison_gate_a: assert property (poison_report_o == $past(poison_valid_i && ctl_q[0]))
        else $error("poison report gating wrong");
    err_gate_a: assert property (err_fwd_valid_o == $past(err_msg_valid_i && ctl_q[1]))
        else $error("error forward gating wrong");
    err_type_a: assert property (err_msg_valid_i && ctl_q[1] |=>
        err_fwd_type_o == $past(err_msg_type_i)) else $error("forwarded error kind wrong");
    mem_fwd_a: assert property (mem_req_valid_i |=> mem_vga_fwd_o ==
        $past(ctl_q[3] && mem_addr_i >= SWS_VGA_MEM_LO && mem_addr_i <= SWS_VGA_MEM_HI))
        else $error("display memory routing wrong");
    hot_lag_a: assert property (hot_reset_o ==
        $past(ctl_q[6] || (!IS_UPSTREAM && up_hot_reset_i))) else $error("hot reset lag wrong");
    port_rst_a: assert property (port_rst_n_o == (IS_UPSTREAM || !hot_reset_o))
        else $error("port reset output wrong");

    cover property (cfg_rvalid_o && $past(cfg_addr_i) == 8'h40);
    cover property (poison_report_o);
    cover property (mem_vga_fwd_o);
    cover property (hot_reset_o && !port_rst_n_o);
endmodule

bind sws_port_ctrl sws_port_ctrl_assertions #(.IS_UPSTREAM(IS_UPSTREAM)) u_chk (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i),
    .cfg_addr_i(cfg_addr_i), .cfg_be_i(cfg_be_i), .cfg_wdata_i(cfg_wdata_i),
    .cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o), .poison_valid_i(poison_valid_i),
    .poison_report_o(poison_report_o), .err_msg_valid_i(err_msg_valid_i),
    .err_msg_type_i(err_msg_type_i), .err_fwd_valid_o(err_fwd_valid_o),
    .err_fwd_type_o(err_fwd_type_o), .mem_req_valid_i(mem_req_valid_i),
    .mem_addr_i(mem_addr_i), .mem_vga_fwd_o(mem_vga_fwd_o), .up_hot_reset_i(up_hot_reset_i),
    .hot_reset_o(hot_reset_o), .port_rst_n_o(port_rst_n_o));

//--- verif/sws_sec_model.sv
/* Secondary side source of poisoned packets and error messages.
   Assumes the bench calls its tasks; port reset comes from the port. */
`timescale 1ns/1ps
module sws_sec_model (
    input wire logic sys_clk_i,
    input wire logic port_rst_n_i,
    output logic poison_valid_o,
    output logic err_msg_valid_o,
    output logic [1:0] err_msg_type_o
);
    // Idle at time zero; the kind line carries junk between messages
    initial begin
        poison_valid_o = 1'b0;
        err_msg_valid_o = 1'b0;
        err_msg_type_o = 2'h3;
    end
    // One poisoned packet; a device held in port reset sends nothing
    task automatic send_poison();
        @(negedge sys_clk_i);
        poison_valid_o = port_rst_n_i;
        @(negedge sys_clk_i);
        poison_valid_o = 1'b0;
    endtask
    // One error message, then the kind line is inverted, not held
    task automatic send_err(input logic [1:0] t);
        @(negedge sys_clk_i);
        {err_msg_valid_o, err_msg_type_o} = {port_rst_n_i, t};
        @(negedge sys_clk_i);
        {err_msg_valid_o, err_msg_type_o} = {1'b0, ~t};
    endtask
endmodule

//--- verif/tb_top.sv
/* Self-checking bench for one downstream sws_port_ctrl.
   Assumes the checker is bound and the secondary model drives faults. */
`timescale 1ns/1ps
module tb_top;
    logic sys_clk, rst_n, cfg_wr, cfg_rd, cfg_rvalid, ld_valid, poison_valid, poison_report;
    logic err_msg_valid, err_fwd_valid, io_req_valid, io_in_window, io_route_valid, io_dn;
    logic io_up, mem_req_valid, mem_route_valid, mem_vga_fwd, up_hot_reset, hot_reset;
    logic dn_hot_reset, port_rst_n;
    logic [7:0] cfg_addr;
    logic [3:0] cfg_be;
    logic [31:0] cfg_wdata, cfg_rdata, io_addr;
    logic [10:0] ld_data;
    logic [1:0] err_msg_type, err_fwd_type;
    int num_errors = 0;
    int n_checks = 0;

    sws_port_ctrl u_dut (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .cfg_wr_i(cfg_wr),
        .cfg_rd_i(cfg_rd), .cfg_addr_i(cfg_addr), .cfg_be_i(cfg_be), .cfg_wdata_i(cfg_wdata),
        .cfg_rdata_o(cfg_rdata), .cfg_rvalid_o(cfg_rvalid), .ld_valid_i(ld_valid),
        .ld_data_i(ld_data), .poison_valid_i(poison_valid), .poison_report_o(poison_report),
        .err_msg_valid_i(err_msg_valid), .err_msg_type_i(err_msg_type),
        .err_fwd_valid_o(err_fwd_valid), .err_fwd_type_o(err_fwd_type),
        .io_req_valid_i(io_req_valid), .io_addr_i(io_addr), .io_in_window_i(io_in_window),
        .io_route_valid_o(io_route_valid), .io_to_downstream_o(io_dn), .io_to_upstream_o(io_up),
        .mem_req_valid_i(mem_req_valid), .mem_addr_i(io_addr),
        .mem_route_valid_o(mem_route_valid), .mem_vga_fwd_o(mem_vga_fwd),
        .up_hot_reset_i(up_hot_reset), .hot_reset_o(hot_reset), .dn_hot_reset_o(dn_hot_reset),
        .port_rst_n_o(port_rst_n));
    sws_sec_model u_sec (.sys_clk_i(sys_clk), .port_rst_n_i(port_rst_n),
        .poison_valid_o(poison_valid), .err_msg_valid_o(err_msg_valid),
        .err_msg_type_o(err_msg_type));

    // 20 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(negedge sys_clk);
        {cfg_wr, cfg_addr, cfg_be, cfg_wdata} = {1'b1, a, be, d};
        @(negedge sys_clk);
        cfg_wr = 1'b0;
    endtask
    // Read answer lands on the same edge that takes the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
        @(negedge sys_clk);
        {cfg_rd, cfg_addr} = {1'b1, a};
        @(negedge sys_clk);
        cfg_rd = 1'b0;
        chk(name, exp, cfg_rdata);
    endtask
    task automatic reset_dut(input int n);
        @(negedge sys_clk);
        rst_n = 1'b0;
        repeat (n) @(negedge sys_clk);
        rst_n = 1'b1;
    endtask
    // One I/O and one memory request on the same address
    task automatic route(input logic [6:0] c, input logic [31:0] a, input logic w,
                         input logic dn, input logic m);
        wr(8'h3c, 4'h4, {9'h000, c, 16'h0000});
        @(negedge sys_clk);
        {io_req_valid, mem_req_valid, io_addr, io_in_window} = {2'b11, a, w};
        @(negedge sys_clk);
        {io_req_valid, mem_req_valid} = 2'b00;
        chk("io_dir", {29'h0, 1'b1, dn, !dn}, {29'h0, io_route_valid, io_dn, io_up});
        chk("mem_fwd", {30'h0, 1'b1, m}, {30'h0, mem_route_valid, mem_vga_fwd});
    endtask

    task automatic t_reset_ro();
        rd(8'h3c, 32'h0000_0000, "bc_reset");
        rd(8'h40, 32'hffc3_4c01, "cap_reset");
        rd(8'h44, 32'h0000_0000, "unmapped");
        wr(8'h3c, 4'hf, 32'hffff_ffff);
        rd(8'h3c, 32'h005f_0000, "bc_ro_bits");
        wr(8'h40, 4'hf, 32'h0000_0000);
        rd(8'h40, 32'hffc3_4c01, "cap_write");
        wr(8'h3c, 4'hb, 32'h0000_0000);
        rd(8'h3c, 32'h005f_0000, "bc_lanes");
        $display("test reset and read-only done");
    endtask
    task automatic t_loader();
        {ld_valid, ld_data} = {1'b1, 11'h000};
        @(negedge sys_clk);
        {ld_valid, ld_data} = {1'b1, 11'h2a5};
        @(negedge sys_clk);
        ld_valid = 1'b0;
        rd(8'h40, 32'h54a3_4c01, "cap_load");
        {ld_valid, ld_data} = {1'b1, 11'h7ff};
        @(negedge sys_clk);
        ld_valid = 1'b0;
        rd(8'h40, 32'hffe3_4c01, "cap_load_dsi");
        reset_dut(2);
        rd(8'h40, 32'hffc3_4c01, "cap_rereset");
        rd(8'h3c, 32'h0000_0000, "bc_rereset");
        $display("test loader done");
    endtask
    task automatic t_fault();
        u_sec.send_poison();
        chk("poison_off", 32'h0, {31'h0, poison_report});
        u_sec.send_err(2'd2);
        chk("err_off", 32'h0, {31'h0, err_fwd_valid});
        wr(8'h3c, 4'h4, 32'h0003_0000);
        u_sec.send_poison();
        chk("poison_on", 32'h1, {31'h0, poison_report});
        for (int t = 0; t < 3; t++) begin
            u_sec.send_err(2'(t));
            chk("err_on", {29'h0, 1'b1, 2'(t)}, {29'h0, err_fwd_valid, err_fwd_type});
        end
        $display("test fault gating done");
    endtask
    task automatic t_route();
        route(7'h08, 32'h0000_03c0, 1'b0, 1'b1, 1'b0);
        route(7'h08, 32'h0000_03bb, 1'b0, 1'b1, 1'b0);
        route(7'h08, 32'h0000_03bc, 1'b0, 1'b0, 1'b0);
        route(7'h00, 32'h0000_03c0, 1'b0, 1'b0, 1'b0);
        route(7'h08, 32'h0000_07df, 1'b0, 1'b1, 1'b0);
        route(7'h18, 32'h0000_07df, 1'b0, 1'b0, 1'b0);
        route(7'h18, 32'h0000_03df, 1'b0, 1'b1, 1'b0);
        route(7'h08, 32'h0001_03c0, 1'b0, 1'b0, 1'b0);
        route(7'h04, 32'h0000_0100, 1'b1, 1'b0, 1'b0);
        route(7'h04, 32'h0000_00ff, 1'b1, 1'b1, 1'b0);
        route(7'h00, 32'h0000_0100, 1'b1, 1'b1, 1'b0);
        route(7'h04, 32'h0001_0100, 1'b1, 1'b1, 1'b0);
        route(7'h0c, 32'h0000_03c0, 1'b1, 1'b1, 1'b0);
        route(7'h08, 32'h000a_0000, 1'b0, 1'b0, 1'b1);
        route(7'h08, 32'h000b_ffff, 1'b0, 1'b0, 1'b1);
        route(7'h08, 32'h000c_0000, 1'b0, 1'b0, 1'b0);
        route(7'h08, 32'h0009_ffff, 1'b0, 1'b0, 1'b0);
        route(7'h00, 32'h000a_0000, 1'b0, 1'b0, 1'b0);
        $display("test routing done");
    endtask
    task automatic t_hot();
        wr(8'h3c, 4'h4, 32'h0040_0000);
        @(negedge sys_clk);
        chk("hot_set", 32'h2, {30'h0, hot_reset, port_rst_n});
        wr(8'h3c, 4'h4, 32'h0000_0000);
        @(negedge sys_clk);
        chk("hot_clear", 32'h1, {30'h0, hot_reset, port_rst_n});
        up_hot_reset = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk("up_hot", 32'h2, {29'h0, dn_hot_reset, hot_reset, port_rst_n});
        up_hot_reset = 1'b0;
        repeat (2) @(negedge sys_clk);
        chk("up_release", 32'h1, {30'h0, hot_reset, port_rst_n});
        $display("test hot reset done");
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Whole run is about 150 cycles; cut off well beyond it
    initial begin
        repeat (5000) @(posedge sys_clk);
        num_errors++;
        complete_run();
    end
    initial begin
        {rst_n, cfg_wr, cfg_rd, ld_valid, io_req_valid, mem_req_valid, io_in_window} = '0;
        {cfg_addr, cfg_be, cfg_wdata, ld_data, io_addr, up_hot_reset} = '0;
        repeat (20) @(negedge sys_clk);
        rst_n = 1'b1;
        t_reset_ro();
        t_loader();
        t_fault();
        t_route();
        t_hot();
        complete_run();
    end
endmodule
